// ### opcr_pkg.sv
package opcr_pkg;

	// ==========================================
	// register indices (printed offsets are not word multiples)
	localparam logic [11:0] OPCR_IDX_DOUT0 = 12'h289;
	localparam logic [11:0] OPCR_IDX_DOUT1 = 12'h28a;
	localparam logic [11:0] OPCR_IDX_DOUT2 = 12'h28b;
	localparam logic [11:0] OPCR_IDX_DOUT3 = 12'h28c;
	localparam logic [11:0] OPCR_IDX_DOUT4 = 12'h28d;
	localparam logic [11:0] OPCR_IDX_DOUT5 = 12'h28e;
	localparam logic [11:0] OPCR_IDX_SVALID = 12'h291;
	localparam logic [11:0] OPCR_IDX_OSC = 12'h292;

	// ==========================================
	// field layout and reset values
	localparam int OPCR_PULL_BIT = 2;
	localparam int OPCR_DRIVE_LSB = 0;
	localparam int OPCR_OSC_DRV_BIT = 1;
	localparam int OPCR_OSC_EN_BIT = 0;
	localparam logic [15:0] OPCR_PAD_RESET = 16'h0000;
	localparam logic [15:0] OPCR_OSC_RESET = 16'h0000;
	localparam logic [15:0] OPCR_PAD_MASK = 16'h0007;
	localparam logic [15:0] OPCR_OSC_MASK = 16'h0003;
	localparam int OPCR_DATA_PINS = 6;

	// ==========================================
	// types
	typedef enum logic [1:0]
	{
		OPCR_DRV_LOWEST = 2'h0,
		OPCR_DRV_LOW = 2'h1,
		OPCR_DRV_HIGH = 2'h2,
		OPCR_DRV_HIGHEST = 2'h3
	} opcr_drive_t;

	typedef enum logic [1:0]
	{
		OPCR_ST_IDLE = 2'h0,
		OPCR_ST_RESP = 2'h1
	} opcr_state_t;

	localparam logic [1:0] OPCR_RESP_OKAY = 2'h0;
	localparam logic [1:0] OPCR_RESP_SLVERR = 2'h2;

endpackage : opcr_pkg

// ### opcr_reg_if.sv
`timescale 1ns/1ps
interface opcr_reg_if;
	logic wr_en;
	logic [11:0] wr_idx;
	logic [15:0] wr_data;
	logic [11:0] rd_idx;
	logic [15:0] rd_data;
	logic rd_hit;
	logic wr_hit;
	modport bus
	(
		output wr_en,
		output wr_idx,
		output wr_data,
		output rd_idx,
		input rd_data,
		input rd_hit,
		input wr_hit
	);
	modport regs
	(
		input wr_en,
		input wr_idx,
		input wr_data,
		input rd_idx,
		output rd_data,
		output rd_hit,
		output wr_hit
	);
endinterface : opcr_reg_if

// ### opcr_reg_bank.sv
`timescale 1ns/1ps
module opcr_reg_bank
(
	input wire logic aclk,
	input wire logic aresetn,
	opcr_reg_if.regs rif,
	output logic [3*opcr_pkg::OPCR_DATA_PINS-1:0] data_pad_ctrl,
	output logic [2:0] svalid_pad_ctrl,
	output logic [1:0] osc_ctrl
);
	import opcr_pkg::*;

	// ==========================================
	// decode
	function automatic logic [3:0] opcr_decode(input logic [11:0] idx);
		// bit 3 = hit, [2:0] = slot; slots 0..5 data, 6 sample valid, 7 osc
		if (idx >= OPCR_IDX_DOUT0 && idx <= OPCR_IDX_DOUT5)
			opcr_decode = {1'b1, 3'(idx - OPCR_IDX_DOUT0)};
		else if (idx == OPCR_IDX_SVALID)
			opcr_decode = 4'hf & {1'b1, 3'h6};
		else if (idx == OPCR_IDX_OSC)
			opcr_decode = {1'b1, 3'h7};
		else
			opcr_decode = 4'h0;
	endfunction : opcr_decode

	logic [3:0] wdec;
	logic [3:0] rdec;
	logic [2:0] pad_ff [0:6];
	logic [1:0] osc_ff;

	assign wdec = opcr_decode(rif.wr_idx);
	assign rdec = opcr_decode(rif.rd_idx);
	assign rif.wr_hit = wdec[3];
	assign rif.rd_hit = rdec[3];

	// ==========================================
	// pad registers
	genvar g;
	generate
		for (g = 0; g < 7; g++)
		begin : g_pad
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					pad_ff[g] <= OPCR_PAD_RESET[2:0];
				else if (rif.wr_en && wdec == {1'b1, 3'(g)})
					pad_ff[g] <= rif.wr_data[2:0];
			end
		end
		for (g = 0; g < OPCR_DATA_PINS; g++)
		begin : g_out
			assign data_pad_ctrl[3*g +: 3] = pad_ff[g];
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			osc_ff <= OPCR_OSC_RESET[1:0];
		else if (rif.wr_en && wdec == 4'hf)
			osc_ff <= rif.wr_data[1:0];
	end

	assign svalid_pad_ctrl = pad_ff[6];
	assign osc_ctrl = osc_ff;

	// ==========================================
	// read mux, upper bits zero
	always_comb
	begin
		rif.rd_data = 16'h0000;
		if (rdec == 4'hf)
			rif.rd_data = {14'h0000, osc_ff};
		else if (rdec[3])
			rif.rd_data = {13'h0000, pad_ff[rdec[2:0]]};
	end
endmodule : opcr_reg_bank

// ### opcr_top.sv
`timescale 1ns/1ps
// How it works
// - six data-output pad registers sit at indices 0x289 to 0x28e, one per data pin 0 to 5.
// - each data-output pad register resets to 0x0000, pull-down off and lowest drive.
// - bit 2 is the read-write pull-down enable and bits 1:0 the drive level.
// - drive level 00 lowest, 01 low, 10 high, 11 highest, for that register's pin only.
// - the sample-valid pad register sits at 0x291, resets to 0x0000, same layout.
// - the oscillator control register sits at 0x292 and resets to 0x0000.
// - stored fields are driven continuously to each pin's pad control inputs.
// - oscillator register bit 1 selects oscillator output drive, 0 low, 1 high, reset 0.
module opcr_top
(
	aclk,
	aresetn,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	sample_data_out_pin_pull,
	sample_data_out_pin_drive,
	sample_valid_pin_pull,
	sample_valid_pin_drive,
	osc_out_drive_level,
	osc_disable
);
	import opcr_pkg::*;

	input wire logic aclk;
	input wire logic aresetn;
	input wire logic [15:0] s_axi_awaddr;
	input wire logic s_axi_awvalid;
	output logic s_axi_awready;
	input wire logic [31:0] s_axi_wdata;
	input wire logic [3:0] s_axi_wstrb;
	input wire logic s_axi_wvalid;
	output logic s_axi_wready;
	output logic [1:0] s_axi_bresp;
	output logic s_axi_bvalid;
	input wire logic s_axi_bready;
	input wire logic [15:0] s_axi_araddr;
	input wire logic s_axi_arvalid;
	output logic s_axi_arready;
	output logic [31:0] s_axi_rdata;
	output logic [1:0] s_axi_rresp;
	output logic s_axi_rvalid;
	input wire logic s_axi_rready;
	output logic [opcr_pkg::OPCR_DATA_PINS-1:0] sample_data_out_pin_pull;
	output logic [2*opcr_pkg::OPCR_DATA_PINS-1:0] sample_data_out_pin_drive;
	output logic sample_valid_pin_pull;
	output logic [1:0] sample_valid_pin_drive;
	output logic osc_out_drive_level;
	output logic osc_disable;

	// ==========================================
	// write channel state
	logic aw_held_ff;
	logic w_held_ff;
	logic [11:0] aw_idx_ff;
	logic [15:0] w_data_ff;
	logic [1:0] w_strb_ff;
	logic wr_go;
	logic [31:0] rd_word;
	logic [3*OPCR_DATA_PINS-1:0] data_pad;
	logic [2:0] sv_pad;
	logic [1:0] osc;

	opcr_reg_if rif();

	// ready flags kept in flops so no port is combinational
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_awready <= 1'b1;
		else if (s_axi_awvalid && s_axi_awready)
			s_axi_awready <= 1'b0;
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_awready <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_wready <= 1'b1;
		else if (s_axi_wvalid && s_axi_wready)
			s_axi_wready <= 1'b0;
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_wready <= 1'b1;
	end

	// both halves held: commit in one cycle, answer next
	assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff <= 1'b0;
			aw_idx_ff <= 12'h000;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_ff <= 1'b1;
			aw_idx_ff <= s_axi_awaddr[13:2];
		end
		else if (wr_go)
			aw_held_ff <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_ff <= 1'b0;
			w_data_ff <= 16'h0000;
			w_strb_ff <= 2'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_ff <= 1'b1;
			w_data_ff <= s_axi_wdata[15:0];
			w_strb_ff <= s_axi_wstrb[1:0];
		end
		else if (wr_go)
			w_held_ff <= 1'b0;
	end

	// ==========================================
	// register bank hookup
	// only lane 0 carries defined bits; upper lanes ignored
	assign rif.wr_en = wr_go && w_strb_ff[0];
	assign rif.wr_idx = aw_idx_ff;
	assign rif.wr_data = w_data_ff;
	assign rif.rd_idx = s_axi_araddr[13:2];
	assign rd_word = {16'h0000, rif.rd_data};

	opcr_reg_bank u_bank
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.rif(rif.regs),
		.data_pad_ctrl(data_pad),
		.svalid_pad_ctrl(sv_pad),
		.osc_ctrl(osc)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= OPCR_RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= rif.wr_hit ? OPCR_RESP_OKAY : OPCR_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ==========================================
	// read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_arready <= 1'b1;
		else if (s_axi_arvalid && s_axi_arready)
			s_axi_arready <= 1'b0;
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_arready <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= OPCR_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rif.rd_hit ? OPCR_RESP_OKAY : OPCR_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ==========================================
	// pad outputs, registered copies of the bank
	genvar g;
	generate
		for (g = 0; g < OPCR_DATA_PINS; g++)
		begin : g_pin
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					sample_data_out_pin_pull[g] <= 1'b0;
					sample_data_out_pin_drive[2*g +: 2] <= OPCR_DRV_LOWEST;
				end
				else
				begin
					sample_data_out_pin_pull[g] <= data_pad[3*g+OPCR_PULL_BIT];
					sample_data_out_pin_drive[2*g +: 2] <= data_pad[3*g +: 2];
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sample_valid_pin_pull <= 1'b0;
			sample_valid_pin_drive <= OPCR_DRV_LOWEST;
			osc_out_drive_level <= 1'b0;
			osc_disable <= 1'b0;
		end
		else
		begin
			sample_valid_pin_pull <= sv_pad[OPCR_PULL_BIT];
			sample_valid_pin_drive <= sv_pad[1:0];
			osc_out_drive_level <= osc[OPCR_OSC_DRV_BIT];
			osc_disable <= osc[OPCR_OSC_EN_BIT];
		end
	end
endmodule : opcr_top

// ### opcr_top_assertions.sv
`timescale 1ns/1ps
module opcr_top_assertions
(
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [5:0] sample_data_out_pin_pull,
	input logic [11:0] sample_data_out_pin_drive,
	input logic sample_valid_pin_pull,
	input logic [1:0] sample_valid_pin_drive,
	input logic osc_out_drive_level,
	input logic osc_disable
);
	import opcr_pkg::*;
	logic [22:0] pads;
	assign pads = {sample_data_out_pin_pull, sample_data_out_pin_drive, sample_valid_pin_pull,
		sample_valid_pin_drive, osc_out_drive_level, osc_disable};
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ====
	// write and read paths
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_rst;
		$rose(aresetn) |-> pads == 23'h0;
	endproperty
	property p_wr;
		s_wr_take |-> ##2 s_axi_bvalid;
	endproperty
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_bblk;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_rd;
		s_rd_take |=> s_axi_rvalid;
	endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_rblk;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_rup;
		s_axi_rvalid |-> s_axi_rdata[31:3] == 29'h0;
	endproperty
	property p_rerr;
		s_axi_rvalid && s_axi_rresp == OPCR_RESP_SLVERR |-> s_axi_rdata == 32'h0;
	endproperty
	// pads only move one cycle after a write commits
	property p_pad;
		!$stable(pads) |-> $past(s_axi_bvalid);
	endproperty
	a_rst: assert property (p_rst) else $error("pads not cleared by reset");
	a_wr: assert property (p_wr) else $error("write response late");
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	a_bblk: assert property (p_bblk) else $error("write taken during response");
	a_rd: assert property (p_rd) else $error("read data late");
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	a_rblk: assert property (p_rblk) else $error("read taken during response");
	a_rup: assert property (p_rup) else $error("upper bits not zero");
	a_rerr: assert property (p_rerr) else $error("error read not zero");
	a_pad: assert property (p_pad) else $error("pad moved without write");
endmodule : opcr_top_assertions
bind opcr_top opcr_top_assertions chk (.*);

// ### tb_opcr_top.sv
`timescale 1ns/1ps
module tb_opcr_top;
	import opcr_pkg::*;
	logic aclk = 0;
	logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [5:0] sample_data_out_pin_pull;
	logic [11:0] sample_data_out_pin_drive;
	logic sample_valid_pin_pull, osc_out_drive_level, osc_disable;
	logic [1:0] sample_valid_pin_drive;
	logic [11:0] ix [8] = '{OPCR_IDX_DOUT0, OPCR_IDX_DOUT1, OPCR_IDX_DOUT2, OPCR_IDX_DOUT3,
		OPCR_IDX_DOUT4, OPCR_IDX_DOUT5, OPCR_IDX_SVALID, OPCR_IDX_OSC};
	logic [15:0] m [8];
	int mismatches = 0;
	int n_compared = 0;
	opcr_top dut (.*);
	always #2.5 aclk = ~aclk;
	// ====
	// bus and compare helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// response ready raised after a random delay so held responses are seen
	task automatic wr(input logic [15:0] a, input logic [31:0] dd, input logic [3:0] s);
		int k;
		logic hs;
		k = $urandom_range(4);
		s_axi_awaddr <= a;
		s_axi_wdata <= dd;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (k == 0);
		do
		begin
			@(posedge aclk);
			hs = s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1;
			if (s_axi_awready === 1'b1 && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1 && s_axi_wvalid) s_axi_wvalid <= 1'b0;
			if (k > 0) k--;
			if (k == 0 && !hs) s_axi_bready <= 1'b1;
		end while (!hs);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [15:0] a);
		int k;
		logic hs;
		k = $urandom_range(3);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (k == 0);
		do
		begin
			@(posedge aclk);
			hs = s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1;
			if (s_axi_arready === 1'b1 && s_axi_arvalid) s_axi_arvalid <= 1'b0;
			if (k > 0) k--;
			if (k == 0 && !hs) s_axi_rready <= 1'b1;
		end while (!hs);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	task automatic pads;
		for (int i = 0; i < 6; i++)
			chk(32'({sample_data_out_pin_pull[i], sample_data_out_pin_drive[2*i+:2]}), m[i]);
		chk(32'({sample_valid_pin_pull, sample_valid_pin_drive}), m[6]);
		chk(32'({osc_out_drive_level, osc_disable}), m[7]);
	endtask : pads
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// ====
	// main sequence
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		v = $urandom(32'h1026);
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 8; i++)
		begin
			m[i] = 16'h0;
			rd({2'h0, ix[i], 2'h0});
			chk(d, 32'h0);
		end
		pads();
		$display("reset test done");
		// every drive code on every register, random upper bits
		for (int p = 0; p < 4; p++)
			for (int i = 0; i < 8; i++)
			begin
				v = $urandom();
				v[1:0] = 2'(p);
				wr({2'h0, ix[i], 2'h0}, v, 4'hf);
				chk(r, OPCR_RESP_OKAY);
				m[i] = v[15:0] & (i < 7 ? OPCR_PAD_MASK : OPCR_OSC_MASK);
				rd({2'h0, ix[i], 2'h0});
				chk(d, m[i]);
				pads();
			end
		$display("write test done");
		wr(16'ha3c, 32'h7, 4'hf);
		chk(r, OPCR_RESP_SLVERR);
		rd(16'ha3c);
		chk(32'(r), 32'(OPCR_RESP_SLVERR));
		chk(d, 32'h0);
		pads();
		wr({2'h0, ix[0], 2'h0}, ~32'(m[0]), 4'he);
		chk(32'(r), 32'(OPCR_RESP_OKAY));
		rd({2'h0, ix[0], 2'h0});
		chk(d, m[0]);
		pads();
		$display("refusal test done");
		wrap_up();
	end
	initial
	begin
		#25000;
		mismatches++;
		wrap_up();
	end
endmodule : tb_opcr_top
